/* File: hdl/gptc_pkg.sv */
// Purpose: constants, register map and state layout of the general purpose timer core
// Assumes: 32-bit classic Wishbone register slave, byte addresses on wb_adr_i
// Notes:   every offset, field position, reset value and divider count lives here
package gptc_pkg;

  // register byte offsets
  localparam logic [7:0] OFF_CONFIG   = 8'h00;
  localparam logic [7:0] OFF_A_MODE   = 8'h04;
  localparam logic [7:0] OFF_B_MODE   = 8'h08;
  localparam logic [7:0] OFF_CONTROL  = 8'h0C;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h18;
  localparam logic [7:0] OFF_RAW_STAT = 8'h1C;
  localparam logic [7:0] OFF_MSK_STAT = 8'h20;
  localparam logic [7:0] OFF_IRQ_CLR  = 8'h24;
  localparam logic [7:0] OFF_A_LOAD   = 8'h28;
  localparam logic [7:0] OFF_B_LOAD   = 8'h2C;
  localparam logic [7:0] OFF_A_MATCH  = 8'h30;
  localparam logic [7:0] OFF_A_PRESC  = 8'h38;
  localparam logic [7:0] OFF_B_PRESC  = 8'h3C;
  localparam logic [7:0] OFF_A_VALUE  = 8'h48;
  localparam logic [7:0] OFF_B_VALUE  = 8'h4C;

  // configuration and mode encodings
  localparam logic [2:0] CFG_WIDE   = 3'h0;
  localparam logic [2:0] CFG_RTC    = 3'h1;
  localparam logic [2:0] CFG_NARROW = 3'h4;
  localparam logic [1:0] MODE_ONE   = 2'h1;
  localparam logic [1:0] MODE_PER   = 2'h2;

  // control register bit positions
  localparam int CTL_A_EN    = 0;
  localparam int CTL_A_STALL = 1;
  localparam int CTL_RTC_OVR = 4;
  localparam int CTL_A_TRIG  = 5;
  localparam int CTL_B_EN    = 8;
  localparam int CTL_B_STALL = 9;
  localparam int CTL_B_TRIG  = 13;
  localparam logic [15:0] CTL_MASK = 16'h2333;

  // status bit positions, shared by raw, masked, mask and clear registers
  localparam int ST_A_TO = 0;
  localparam int ST_RTC  = 3;
  localparam int ST_B_TO = 8;
  localparam logic [15:0] ST_MASK = 16'h0109;

  // reset and load values
  localparam logic [15:0] CNT_RST   = 16'hFFFF;
  localparam logic [15:0] LOAD_RST  = 16'hFFFF;
  localparam logic [7:0]  PRESC_RST = 8'h00;
  localparam logic [31:0] RTC_START = 32'h0000_0001;

  // reference edges per one-second step
  localparam int RTC_REF_HZ = 32768;
  localparam int RTC_OUT_HZ = 1;
  localparam logic [14:0] RTC_DIV_LAST = 15'(RTC_REF_HZ / RTC_OUT_HZ - 1);

  // whole state of the core
  typedef struct packed {
    logic [2:0]  cfg;
    logic [1:0]  modeA;
    logic [1:0]  modeB;
    logic [15:0] ctl;
    logic [15:0] mask;
    logic [15:0] raw;
    logic [15:0] loadA;
    logic [15:0] loadB;
    logic [15:0] cntA;
    logic [15:0] cntB;
    logic [7:0]  preA;
    logic [7:0]  preB;
    logic [7:0]  pcA;
    logic [7:0]  pcB;
    logic [31:0] match;
    logic [14:0] rtcDiv;
    logic [2:0]  capSync;
    logic        ack;
    logic [31:0] rdData;
    logic        trigA;
    logic        trigB;
    logic        irq;
  } gptc_state_s;

  localparam gptc_state_s STATE_RST = '{
    cfg: CFG_WIDE, modeA: 2'h0, modeB: 2'h0, ctl: 16'h0000, mask: 16'h0000,
    raw: 16'h0000, loadA: LOAD_RST, loadB: LOAD_RST, cntA: CNT_RST, cntB: CNT_RST,
    preA: PRESC_RST, preB: PRESC_RST, pcA: PRESC_RST, pcB: PRESC_RST,
    match: 32'h0000_0000, rtcDiv: 15'h0000, capSync: 3'h0, ack: 1'b0,
    rdData: 32'h0000_0000, trigA: 1'b0, trigB: 1'b0, irq: 1'b0};

endpackage

/* File: hdl/gptc_core.sv */
// Purpose: two 16-bit timers usable as one 32-bit timer, a 32-bit RTC or two 16-bit timers
// Assumes: classic Wishbone slave, one clock, capturePin is an asynchronous 32.768 kHz input
// Notes:   all state sits in one struct; clkEn low freezes every flip-flop
`timescale 1ns/1ps

// Overview of operation
// - config 0 is 32-bit one-shot/periodic, config 1 is 32-bit RTC
// - config 0x4 runs both halves as independent 16-bit timers
// - reset leaves the core idle with control registers at defaults
// - reset sets counters and load registers to 0xFFFF, prescalers to 0x00
// - 32-bit load write fills B load from upper half, A load from lower
// - 32-bit value read returns B counter above A counter
// - 32-bit down-count reloads after zero; one-shot then stops and clears enable
// - zero sets sticky time-out raw flag, masked flag when unmasked
// - trigger enable gives a one-cycle pulse when the counter reaches zero
// - load write while running is taken by the counter next cycle
// - stall bit freezes the timer until it is cleared
// - RTC counts up, starting at 1 when first selected; match register sets reloads
// - reference pin carries 32.768 kHz, divided to one step per second
// - RTC match rolls the count to zero and counting continues
// - RTC match sets raw flag, masked flag and interrupt when unmasked; clear bit clears both
// - RTC stall override keeps the RTC counting despite stall bits
// - 16-bit mode: down-counter with 8-bit prescaler, mode field picks behaviour
// - 16-bit zero reloads load and prescale values; one-shot clears enable
// - 16-bit zero sets that timer's sticky time-out flag, masked flag when unmasked
// - prescale p makes each count step last p+1 clocks
// - mode field 0x1 is one-shot, 0x2 is periodic
module gptc_core (
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        clkEn,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        capturePin,
  output logic             triggerA,
  output logic             triggerB,
  output logic             irqOut
);

  gptc_pkg::gptc_state_s state_r;
  gptc_pkg::gptc_state_s state_nxt;

  logic        reqHit;
  logic        wrEn;
  logic        refEdge;
  logic        evA;
  logic        evB;
  logic        evRtc;
  logic        rtcTick;
  logic        runA;
  logic        runB;
  logic [31:0] cnt32;
  logic [31:0] load32;
  logic [31:0] wrMerged;
  logic [31:0] rdMux;
  logic [15:0] clrBits;
  logic [24:0] stepA;
  logic [24:0] stepB;

  // byte lanes of a write replace only the selected bytes of the old word
  function automatic logic [31:0] laneMerge(input logic [31:0] oldW, input logic [31:0] newW,
                                            input logic [3:0] sel);
    logic [31:0] res;
    res = oldW;
    for (int i = 0; i < 4; i++)
    begin
      if (sel[i])
      begin
        res[i*8 +: 8] = newW[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // one clock of a 16-bit timer: result is {timeout, count, prescale count}
  function automatic logic [24:0] step16(input logic run, input logic [15:0] cnt,
                                         input logic [7:0] pc, input logic [15:0] load,
                                         input logic [7:0] pre);
    logic [24:0] res;
    res = {1'b0, cnt, pc};
    if (run)
    begin
      if (pc != 8'h00)
      begin
        res = {1'b0, cnt, pc - 8'h01};
      end
      else if (cnt == 16'h0000)
      begin
        res = {1'b1, load, pre};
      end
      else
      begin
        res = {1'b0, cnt - 16'h0001, pre};
      end
    end
    return res;
  endfunction

  // bus qualifiers and reference edge after the two-stage synchroniser
  assign reqHit  = wb_cyc_i && wb_stb_i;
  assign wrEn    = reqHit && wb_we_i && state_r.ack;
  assign refEdge = state_r.capSync[1] && !state_r.capSync[2];
  assign cnt32   = {state_r.cntB, state_r.cntA};
  assign load32  = {state_r.loadB, state_r.loadA};

  // read data multiplexer
  always_comb
  begin
    rdMux = 32'h0000_0000;
    if (wb_adr_i == gptc_pkg::OFF_CONFIG)
      rdMux = {29'h0, state_r.cfg};
    else if (wb_adr_i == gptc_pkg::OFF_A_MODE)
      rdMux = {30'h0, state_r.modeA};
    else if (wb_adr_i == gptc_pkg::OFF_B_MODE)
      rdMux = {30'h0, state_r.modeB};
    else if (wb_adr_i == gptc_pkg::OFF_CONTROL)
      rdMux = {16'h0, state_r.ctl};
    else if (wb_adr_i == gptc_pkg::OFF_IRQ_MASK)
      rdMux = {16'h0, state_r.mask};
    else if (wb_adr_i == gptc_pkg::OFF_RAW_STAT)
      rdMux = {16'h0, state_r.raw};
    else if (wb_adr_i == gptc_pkg::OFF_MSK_STAT)
      rdMux = {16'h0, state_r.raw & state_r.mask};
    else if (wb_adr_i == gptc_pkg::OFF_A_LOAD)
      rdMux = (state_r.cfg == gptc_pkg::CFG_NARROW) ? {16'h0, state_r.loadA} : load32;
    else if (wb_adr_i == gptc_pkg::OFF_B_LOAD)
      rdMux = {16'h0, state_r.loadB};
    else if (wb_adr_i == gptc_pkg::OFF_A_MATCH)
      rdMux = state_r.match;
    else if (wb_adr_i == gptc_pkg::OFF_A_PRESC)
      rdMux = {24'h0, state_r.preA};
    else if (wb_adr_i == gptc_pkg::OFF_B_PRESC)
      rdMux = {24'h0, state_r.preB};
    else if (wb_adr_i == gptc_pkg::OFF_A_VALUE)
      rdMux = (state_r.cfg == gptc_pkg::CFG_NARROW) ? {16'h0, state_r.cntA} : cnt32;
    else if (wb_adr_i == gptc_pkg::OFF_B_VALUE)
      rdMux = {16'h0, state_r.cntB};
  end

  // counting, register writes and status: hardware first, software writes override except status clears
  always_comb
  begin
    state_nxt = state_r;
    evA = 1'b0;
    evB = 1'b0;
    evRtc = 1'b0;
    rtcTick = 1'b0;
    runA = state_r.ctl[gptc_pkg::CTL_A_EN] && !state_r.ctl[gptc_pkg::CTL_A_STALL]
           && (state_r.modeA == gptc_pkg::MODE_ONE || state_r.modeA == gptc_pkg::MODE_PER);
    runB = state_r.ctl[gptc_pkg::CTL_B_EN] && !state_r.ctl[gptc_pkg::CTL_B_STALL]
           && (state_r.modeB == gptc_pkg::MODE_ONE || state_r.modeB == gptc_pkg::MODE_PER);
    stepA = step16(runA && state_r.cfg == gptc_pkg::CFG_NARROW, state_r.cntA, state_r.pcA,
                   state_r.loadA, state_r.preA);
    stepB = step16(runB && state_r.cfg == gptc_pkg::CFG_NARROW, state_r.cntB, state_r.pcB,
                   state_r.loadB, state_r.preB);
    wrMerged = 32'h0000_0000;
    clrBits = 16'h0000;
    state_nxt.capSync = {state_r.capSync[1:0], capturePin};

    // 32-bit one-shot/periodic down-counter
    if (state_r.cfg == gptc_pkg::CFG_WIDE && runA)
    begin
      if (cnt32 == 32'h0000_0000)
      begin
        {state_nxt.cntB, state_nxt.cntA} = load32;
        evA = 1'b1;
        if (state_r.modeA == gptc_pkg::MODE_ONE)
          state_nxt.ctl[gptc_pkg::CTL_A_EN] = 1'b0;
      end
      else
      begin
        {state_nxt.cntB, state_nxt.cntA} = cnt32 - 32'h0000_0001;
      end
    end

    // 32-bit RTC: divide reference edges to one step per second, count up to match
    if (state_r.cfg == gptc_pkg::CFG_RTC && state_r.ctl[gptc_pkg::CTL_A_EN] && refEdge
        && (state_r.ctl[gptc_pkg::CTL_RTC_OVR]
            || !(state_r.ctl[gptc_pkg::CTL_A_STALL] || state_r.ctl[gptc_pkg::CTL_B_STALL])))
    begin
      if (state_r.rtcDiv == gptc_pkg::RTC_DIV_LAST)
      begin
        state_nxt.rtcDiv = 15'h0000;
        rtcTick = 1'b1;
      end
      else
      begin
        state_nxt.rtcDiv = state_r.rtcDiv + 15'h0001;
      end
    end
    if (rtcTick)
    begin
      if (cnt32 == state_r.match)
      begin
        {state_nxt.cntB, state_nxt.cntA} = 32'h0000_0000;
        evRtc = 1'b1;
      end
      else
      begin
        {state_nxt.cntB, state_nxt.cntA} = cnt32 + 32'h0000_0001;
      end
    end

    // two independent 16-bit timers
    if (state_r.cfg == gptc_pkg::CFG_NARROW)
    begin
      {evA, state_nxt.cntA, state_nxt.pcA} = stepA;
      {evB, state_nxt.cntB, state_nxt.pcB} = stepB;
      if (evA && state_r.modeA == gptc_pkg::MODE_ONE)
        state_nxt.ctl[gptc_pkg::CTL_A_EN] = 1'b0;
      if (evB && state_r.modeB == gptc_pkg::MODE_ONE)
        state_nxt.ctl[gptc_pkg::CTL_B_EN] = 1'b0;
    end

    // register writes, taken on the edge where the master sees ack
    if (wrEn)
    begin
      if (wb_adr_i == gptc_pkg::OFF_CONFIG)
      begin
        wrMerged = laneMerge({29'h0, state_r.cfg}, wb_dat_i, wb_sel_i);
        state_nxt.cfg = wrMerged[2:0];
        if (wrMerged[2:0] == gptc_pkg::CFG_RTC && state_r.cfg != gptc_pkg::CFG_RTC)
        begin
          {state_nxt.cntB, state_nxt.cntA} = gptc_pkg::RTC_START;
          state_nxt.rtcDiv = 15'h0000;
        end
      end
      else if (wb_adr_i == gptc_pkg::OFF_A_MODE)
      begin
        wrMerged = laneMerge({30'h0, state_r.modeA}, wb_dat_i, wb_sel_i);
        state_nxt.modeA = wrMerged[1:0];
      end
      else if (wb_adr_i == gptc_pkg::OFF_B_MODE)
      begin
        wrMerged = laneMerge({30'h0, state_r.modeB}, wb_dat_i, wb_sel_i);
        state_nxt.modeB = wrMerged[1:0];
      end
      else if (wb_adr_i == gptc_pkg::OFF_CONTROL)
      begin
        wrMerged = laneMerge({16'h0, state_r.ctl}, wb_dat_i, wb_sel_i);
        state_nxt.ctl = wrMerged[15:0] & gptc_pkg::CTL_MASK;
        // a fresh enable starts the down-count from the preloaded value
        if (wrMerged[gptc_pkg::CTL_A_EN] && !state_r.ctl[gptc_pkg::CTL_A_EN])
        begin
          if (state_r.cfg == gptc_pkg::CFG_WIDE)
            {state_nxt.cntB, state_nxt.cntA} = load32;
          else if (state_r.cfg == gptc_pkg::CFG_NARROW)
            {state_nxt.cntA, state_nxt.pcA} = {state_r.loadA, state_r.preA};
        end
        if (wrMerged[gptc_pkg::CTL_B_EN] && !state_r.ctl[gptc_pkg::CTL_B_EN]
            && state_r.cfg == gptc_pkg::CFG_NARROW)
          {state_nxt.cntB, state_nxt.pcB} = {state_r.loadB, state_r.preB};
      end
      else if (wb_adr_i == gptc_pkg::OFF_IRQ_MASK)
      begin
        wrMerged = laneMerge({16'h0, state_r.mask}, wb_dat_i, wb_sel_i);
        state_nxt.mask = wrMerged[15:0] & gptc_pkg::ST_MASK;
      end
      else if (wb_adr_i == gptc_pkg::OFF_IRQ_CLR)
      begin
        wrMerged = laneMerge(32'h0000_0000, wb_dat_i, wb_sel_i);
        clrBits = wrMerged[15:0];
      end
      else if (wb_adr_i == gptc_pkg::OFF_A_LOAD)
      begin
        if (state_r.cfg == gptc_pkg::CFG_NARROW)
        begin
          wrMerged = laneMerge({16'h0, state_r.loadA}, wb_dat_i, wb_sel_i);
          state_nxt.loadA = wrMerged[15:0];
          if (state_r.ctl[gptc_pkg::CTL_A_EN])
            state_nxt.cntA = wrMerged[15:0];
        end
        else
        begin
          wrMerged = laneMerge(load32, wb_dat_i, wb_sel_i);
          {state_nxt.loadB, state_nxt.loadA} = wrMerged;
          if (state_r.cfg == gptc_pkg::CFG_WIDE && state_r.ctl[gptc_pkg::CTL_A_EN])
            {state_nxt.cntB, state_nxt.cntA} = wrMerged;
        end
      end
      else if (wb_adr_i == gptc_pkg::OFF_B_LOAD)
      begin
        wrMerged = laneMerge({16'h0, state_r.loadB}, wb_dat_i, wb_sel_i);
        state_nxt.loadB = wrMerged[15:0];
        if (state_r.cfg == gptc_pkg::CFG_NARROW && state_r.ctl[gptc_pkg::CTL_B_EN])
          state_nxt.cntB = wrMerged[15:0];
      end
      else if (wb_adr_i == gptc_pkg::OFF_A_MATCH)
      begin
        state_nxt.match = laneMerge(state_r.match, wb_dat_i, wb_sel_i);
      end
      else if (wb_adr_i == gptc_pkg::OFF_A_PRESC)
      begin
        wrMerged = laneMerge({24'h0, state_r.preA}, wb_dat_i, wb_sel_i);
        state_nxt.preA = wrMerged[7:0];
      end
      else if (wb_adr_i == gptc_pkg::OFF_B_PRESC)
      begin
        wrMerged = laneMerge({24'h0, state_r.preB}, wb_dat_i, wb_sel_i);
        state_nxt.preB = wrMerged[7:0];
      end
    end

    // sticky status: a new event wins over a clear in the same cycle
    state_nxt.raw = (state_r.raw & ~clrBits) | ({15'h0, evA} << gptc_pkg::ST_A_TO)
                    | ({15'h0, evRtc} << gptc_pkg::ST_RTC)
                    | ({15'h0, evB} << gptc_pkg::ST_B_TO);
    state_nxt.irq = |(state_nxt.raw & state_r.mask);
    state_nxt.trigA = evA && state_r.ctl[gptc_pkg::CTL_A_TRIG];
    state_nxt.trigB = evB && state_r.ctl[gptc_pkg::CTL_B_TRIG];

    // bus answer one cycle after the request, dropped the cycle after
    state_nxt.ack = reqHit && !state_r.ack;
    state_nxt.rdData = (reqHit && !state_r.ack && !wb_we_i) ? rdMux : 32'h0000_0000;
  end

  // state register, frozen while clkEn is low
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      state_r <= gptc_pkg::STATE_RST;
    else if (clkEn)
      state_r <= state_nxt;
  end

  assign wb_dat_o = state_r.rdData;
  assign wb_ack_o = state_r.ack;
  assign triggerA = state_r.trigA;
  assign triggerB = state_r.trigB;
  assign irqOut   = state_r.irq;

  // checks
  a_reset_values: assert property (@(posedge clock) disable iff (!rst_n)
    $rose(rst_n) |-> state_r.cntA == 16'hFFFF && state_r.loadB == 16'hFFFF
                     && state_r.preA == 8'h00 && state_r.ctl == 16'h0000)
    else $error("reset values wrong");

  a_timeout_sticky: assert property (@(posedge clock) disable iff (!rst_n)
    state_r.raw[0] && !(wrEn && wb_adr_i == 8'h24) |=> state_r.raw[0])
    else $error("time-out flag lost");

  a_trig_cause: assert property (@(posedge clock) disable iff (!rst_n)
    $past(clkEn) && state_r.trigA |-> $past(evA) && $past(state_r.ctl[5]))
    else $error("trigger without zero");

  a_oneshot_stop: assert property (@(posedge clock) disable iff (!rst_n)
    clkEn && evA && state_r.modeA == 2'h1 && !wrEn |=> !state_r.ctl[0])
    else $error("one-shot kept running");

  a_wide_reload: assert property (@(posedge clock) disable iff (!rst_n)
    clkEn && evA && state_r.cfg == 3'h0 && !wrEn
    |=> {state_r.cntB, state_r.cntA} == $past(load32))
    else $error("no reload after zero");

  a_stall_freeze: assert property (@(posedge clock) disable iff (!rst_n)
    clkEn && state_r.cfg == 3'h0 && state_r.ctl[1] && !wrEn
    |=> {state_r.cntB, state_r.cntA} == $past(cnt32))
    else $error("stalled counter moved");

  a_prescale_hold: assert property (@(posedge clock) disable iff (!rst_n)
    clkEn && state_r.cfg == 3'h4 && state_r.pcA != 8'h00 && !wrEn
    |=> state_r.cntA == $past(state_r.cntA) && state_r.pcA == $past(state_r.pcA) - 8'h01)
    else $error("count stepped inside prescale");

  a_rtc_first: assert property (@(posedge clock) disable iff (!rst_n)
    clkEn && wrEn && wb_adr_i == 8'h00 && wb_sel_i[0] && wb_dat_i[2:0] == 3'h1
    && state_r.cfg != 3'h1 |=> {state_r.cntB, state_r.cntA} == 32'h0000_0001)
    else $error("rtc start value wrong");

  a_rtc_roll: assert property (@(posedge clock) disable iff (!rst_n)
    clkEn && rtcTick && cnt32 == state_r.match && !wrEn
    |=> {state_r.cntB, state_r.cntA} == 32'h0000_0000 ##1 state_r.raw[3])
    else $error("rtc did not roll over");

  a_load_live: assert property (@(posedge clock) disable iff (!rst_n)
    clkEn && wrEn && wb_adr_i == 8'h28 && wb_sel_i == 4'hF && state_r.cfg == 3'h4
    && state_r.ctl[0] |=> state_r.cntA == $past(wb_dat_i[15:0]))
    else $error("load not taken by running counter");

  a_wide_read: assert property (@(posedge clock) disable iff (!rst_n)
    clkEn && reqHit && !wb_we_i && !state_r.ack && wb_adr_i == 8'h48 && state_r.cfg == 3'h0
    |=> wb_ack_o && wb_dat_o == $past(cnt32))
    else $error("concatenated read wrong");

endmodule

/* File: tb/gptc_ref_clk_model.sv */
// Purpose: reference clock source feeding the rtc divider pin
// Assumes: the bench switches it on only around rtc traffic
// Notes:   the pin stands low while the source is off
`timescale 1ns/1ps
module gptc_ref_clk_model #(
  parameter int HALF_NS = 15259
) (
  input  wire logic enable,
  output logic      refPin
);
  // free toggling only while enabled, no phase tie to the bus clock
  initial
  begin
    refPin = 1'b0;
    forever
    begin
      #(HALF_NS);
      refPin = enable ? ~refPin : 1'b0;
    end
  end
endmodule

/* File: tb/gptc_core_tb.sv */
// Purpose: self-checking bench for the timer core over its register bus
// Assumes: clock enable tied high, reference source from the partner model
// Notes:   the rtc divider is too long to run a full step here
`timescale 1ns/1ps
module gptc_core_tb;
  logic        clock, rst_n, cyc, stb, we, refOn, capPin, trigA, trigB, irq, ack;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] datI, datO, v1, v2;
  int          mismatches, checks_done, n;

  gptc_core DUT (.clock(clock), .rst_n(rst_n), .clkEn(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(datI), .wb_dat_o(datO),
    .wb_ack_o(ack), .capturePin(capPin), .triggerA(trigA), .triggerB(trigB), .irqOut(irq));
  gptc_ref_clk_model REF (.enable(refOn), .refPin(capPin));

  // bus clock, 40 ns
  initial
  begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  task automatic fail(input string m);
    mismatches++;
    $display("MISMATCH at %0t: %s", $time, m);
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) fail($sformatf("got %h expected %h", got, exp));
  endtask

  task automatic chkTrue(input logic c, input string m);
    checks_done++;
    if (c !== 1'b1) fail(m);
  endtask

  // one classic cycle, held until ack is sampled high
  task automatic wbCycle(input logic w, input logic [7:0] a, input logic [31:0] d,
                         output logic [31:0] r);
    int k;
    @(posedge clock);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    datI <= d;
    k = 0;
    do
    begin
      @(posedge clock);
      k++;
    end
    while (ack !== 1'b1 && k < 50);
    r = datO;
    if (k >= 50) fail("no bus answer");
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    wbCycle(1'b1, a, d, r);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    wbCycle(1'b0, a, 32'h0, r);
  endtask

  task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    wbCycle(1'b0, a, 32'h0, r);
    chk(r, exp);
  endtask

  // waits for a trigger pulse, then sees it gone one cycle later
  task automatic waitPulse(input logic b, output int c);
    c = 0;
    do
    begin
      @(posedge clock);
      #1;
      c++;
    end
    while ((b ? trigB : trigA) !== 1'b1 && c < 2000);
    chkTrue(c < 2000, "trigger missing");
    @(posedge clock);
    #1;
    chkTrue((b ? trigB : trigA) === 1'b0, "trigger too long");
  endtask

  task automatic endTest(input string t);
    $display("test %s finished, mismatches so far %0d", t, mismatches);
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // watchdog far beyond the expected few hundred cycles
  initial
  begin
    #(40 * 20000);
    fail("timeout");
    test_done();
  end

  // main sequence
  initial
  begin
    {cyc, stb, we, refOn, rst_n} = 5'h00;
    adr = 8'h00;
    sel = 4'hF;
    datI = 32'h0;
    mismatches = 0;
    checks_done = 0;
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    rdChk(gptc_pkg::OFF_CONTROL, 32'h0);
    rdChk(gptc_pkg::OFF_CONFIG, 32'h0);
    rdChk(gptc_pkg::OFF_A_LOAD, {gptc_pkg::LOAD_RST, gptc_pkg::LOAD_RST});
    rdChk(gptc_pkg::OFF_A_VALUE, {gptc_pkg::CNT_RST, gptc_pkg::CNT_RST});
    rdChk(gptc_pkg::OFF_B_PRESC, 32'(gptc_pkg::PRESC_RST));
    rdChk(8'h40, 32'h0);
    endTest("reset");
    wr(gptc_pkg::OFF_A_MODE, 32'(gptc_pkg::MODE_ONE));
    wr(gptc_pkg::OFF_A_LOAD, 32'h5);
    wr(gptc_pkg::OFF_IRQ_MASK, 32'h1);
    wr(gptc_pkg::OFF_CONTROL, 32'h21);
    waitPulse(1'b0, n);
    rdChk(gptc_pkg::OFF_CONTROL, 32'h20);
    rdChk(gptc_pkg::OFF_A_VALUE, 32'h5);
    rdChk(gptc_pkg::OFF_RAW_STAT, 32'h1);
    rdChk(gptc_pkg::OFF_MSK_STAT, 32'h1);
    chkTrue(irq === 1'b1, "irq not raised");
    wr(gptc_pkg::OFF_IRQ_CLR, 32'h1);
    rdChk(gptc_pkg::OFF_RAW_STAT, 32'h0);
    endTest("oneshot32");
    wr(gptc_pkg::OFF_A_MODE, 32'(gptc_pkg::MODE_PER));
    wr(gptc_pkg::OFF_A_LOAD, 32'h800);
    wr(gptc_pkg::OFF_CONTROL, 32'h1);
    wr(gptc_pkg::OFF_CONTROL, 32'h3);
    rd(gptc_pkg::OFF_A_VALUE, v1);
    rd(gptc_pkg::OFF_A_VALUE, v2);
    chk(v2, v1);
    wr(gptc_pkg::OFF_CONTROL, 32'h1);
    rd(gptc_pkg::OFF_A_VALUE, v2);
    chkTrue(v2 < v1, "no resume");
    wr(gptc_pkg::OFF_A_LOAD, 32'h0002_0040);
    rd(gptc_pkg::OFF_A_VALUE, v2);
    chkTrue(v2 <= 32'h0002_0040 && v2 > 32'h0002_0030, "live load");
    rdChk(gptc_pkg::OFF_B_LOAD, 32'h2);
    wr(gptc_pkg::OFF_CONTROL, 32'h0);
    endTest("periodic32");
    wr(gptc_pkg::OFF_CONFIG, 32'(gptc_pkg::CFG_NARROW));
    wr(gptc_pkg::OFF_A_MODE, 32'(gptc_pkg::MODE_ONE));
    wr(gptc_pkg::OFF_B_MODE, 32'(gptc_pkg::MODE_PER));
    wr(gptc_pkg::OFF_B_PRESC, 32'h3);
    wr(gptc_pkg::OFF_A_LOAD, 32'h2);
    wr(gptc_pkg::OFF_B_LOAD, 32'h4);
    wr(gptc_pkg::OFF_IRQ_MASK, 32'h100);
    wr(gptc_pkg::OFF_CONTROL, 32'h2121);
    waitPulse(1'b1, n);
    waitPulse(1'b1, n);
    chkTrue(n == (4 + 1) * (3 + 1) - 1, "step period");
    rdChk(gptc_pkg::OFF_CONTROL, 32'h2120);
    wr(gptc_pkg::OFF_CONTROL, 32'h0);
    rdChk(gptc_pkg::OFF_A_VALUE, 32'h2);
    rdChk(gptc_pkg::OFF_RAW_STAT, 32'h101);
    rdChk(gptc_pkg::OFF_MSK_STAT, 32'h100);
    chkTrue(irq === 1'b1, "irq not raised");
    wr(gptc_pkg::OFF_IRQ_CLR, 32'h101);
    rdChk(gptc_pkg::OFF_RAW_STAT, 32'h0);
    endTest("narrow16");
    wr(gptc_pkg::OFF_CONFIG, 32'(gptc_pkg::CFG_RTC));
    rdChk(gptc_pkg::OFF_A_VALUE, gptc_pkg::RTC_START);
    refOn <= 1'b1;
    wr(gptc_pkg::OFF_CONTROL, 32'h1);
    repeat (200) @(posedge clock);
    rdChk(gptc_pkg::OFF_A_VALUE, gptc_pkg::RTC_START);
    refOn <= 1'b0;
    endTest("rtc");
    test_done();
  end
endmodule
